// file: src/ueh_ctrl.sv
// ueh_ctrl: error reporting, interrupt, power state and port sharing of the enhanced host
// assumes: all inputs come from logic on clk_sys; register port answers reads one cycle late
`timescale 1ns/1ps
`include "ueh_cfg.svh"
module ueh_ctrl import ueh_pkg::*; #(
    parameter bit CTRL_SEL = 1'b0,
    parameter int UFRAME_CYC = `UEH_UFRAME_NS / `UEH_CLK_NS
) (
    input wire logic clk_sys, // 10 MHz system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [`UEH_ADDR_W-1:0] regAddr, // register byte address
    input wire logic [31:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [31:0] regRdata, // read data, cycle after strobe
    output logic regAbort, // access master-aborted
    input wire logic dmaReq, // engines want memory
    output logic memGrant, // memory access allowed
    input wire ueh_rdresp_s rdResp, // own memory read completion
    input wire ueh_xact_s xact, // completed USB transaction
    output ueh_wb_s wb, // descriptor writeback fields
    input wire logic sleepS345, // system entering S3/S4/S5
    output logic pllEnable, // PLL enable
    output logic sofPulse, // microframe start
    output logic sharedIrqLineH, // shared interrupt line
    output logic wakeEventSignal, // wake event in D3
    output logic intResetPulse, // D3-to-D0 internal reset
    output logic [3:0] portTestMode, // port test mode
    output logic [`UEH_MAX_PORTS*`UEH_CC_W-1:0] companionMap // companion per port
);
    localparam int NPORTS = CTRL_SEL ? `UEH_PORTS_HC1 : `UEH_PORTS_HC0;
    localparam int PORT_BASE = CTRL_SEL ? `UEH_PORTS_HC0 : 0;
    // decode
    logic isD0, isCfg, accOk, wrEn, rdEn, abortEv, coreClr, mmioClr, irqCause, stsRead;
    logic rollPulse;
    logic [`UEH_FRIDX_W-1:0] frIdx;
    logic [`UEH_MAX_PORTS*`UEH_CC_W-1:0] mapD;
    // power / configuration group
    logic [1:0] pwr_q, pwr_d;
    logic intRst_q, intRst_d;
    logic serrEn_q, serrEn_d, rxMa_q, rxMa_d, rxTa_q, rxTa_d, sigSe_q, sigSe_d;
    logic [31:0] fwParam_q, fwParam_d;
    logic wakeEn_q, wakeEn_d, wakeSts_q, wakeSts_d;
    // operational group
    ueh_dma_e state_q, state_d;
    // abort wait cycles while microframes run
    localparam int ACW = $clog2(UFRAME_CYC + 2);
    logic [ACW-1:0] abortCnt_q, abortCnt_d;
    logic run_q, run_d, pause_q, pause_d, hcRst_q, hcRst_d;
    logic [`UEH_STS_W-1:0] sts_q, sts_d, stsSet, stsClr, inten_q, inten_d;
    ueh_test_e test_q, test_d;
    // outputs
    logic [31:0] rdata_q, rdata_d;
    logic regAbort_q, regAbort_d, grant_q, grant_d, pll_q, pll_d;
    logic irq_q, irq_d, wake_q, wake_d;
    logic [`UEH_MAX_PORTS*`UEH_CC_W-1:0] map_q;
    ueh_wb_s wb_q, wb_d;
    assign isD0 = (pwr_q == `UEH_PWR_D0);
    assign isCfg = (regAddr >= `UEH_CFG_BASE);
    // memory-mapped range is dead in D3; configuration space always answers
    assign accOk = isD0 | isCfg; // [RULE_16]
    assign wrEn = regWr & accOk;
    assign rdEn = regRd & accOk;
    assign stsRead = regRd & isD0 & (regAddr == `UEH_OFS_STS);
    // every read the engines start is ours, so any abort is fatal
    assign abortEv = rdResp.valid & (rdResp.masterAbort | rdResp.targetAbort); // [RULE_03]
    assign coreClr = intRst_q | sleepS345; // [RULE_20] [RULE_23]
    assign mmioClr = coreClr | hcRst_q;
    assign irqCause = |(sts_q & inten_q);
    ueh_frame_timer #(
        .UFRAME_CYC(UFRAME_CYC)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n & ~coreClr),
        // start-of-frame runs while paused too; halting or leaving D0 stops it
        .run(isD0 & (state_q != ST_HALTED)), // [RULE_14]
        .sofPulse(sofPulse),
        .rollPulse(rollPulse),
        .frIdx(frIdx)
    );
    // fixed port to companion pairing, one field per root port
    for (genvar p = 0; p < `UEH_MAX_PORTS; p++) begin : g_map
        if (p < NPORTS) begin : g_used
            assign mapD[p*`UEH_CC_W +: `UEH_CC_W] =
                `UEH_CC_W'((PORT_BASE + p) / `UEH_PORTS_PER_CC); // [RULE_21]
        end else begin : g_none
            assign mapD[p*`UEH_CC_W +: `UEH_CC_W] = `UEH_NO_COMPANION;
        end
    end
    // power and configuration state
    always_comb begin
        pwr_d = pwr_q;
        intRst_d = 1'b0;
        serrEn_d = serrEn_q;
        rxMa_d = rxMa_q | (abortEv & rdResp.masterAbort); // [RULE_12]
        rxTa_d = rxTa_q | (abortEv & rdResp.targetAbort); // [RULE_12]
        sigSe_d = sigSe_q | (abortEv & serrEn_q); // [RULE_13]
        fwParam_d = fwParam_q;
        wakeEn_d = wakeEn_q;
        // wake status lives in the suspend well and survives core resets
        wakeSts_d = wakeSts_q | (!isD0 & irqCause); // [RULE_17]
        if (wrEn && regAddr == `UEH_OFS_PWR) begin
            if (regWdata[1:0] == `UEH_PWR_D0 || regWdata[1:0] == `UEH_PWR_D3) begin
                pwr_d = regWdata[1:0]; // [RULE_15]
            end
            intRst_d = (pwr_q == `UEH_PWR_D3) && (regWdata[1:0] == `UEH_PWR_D0); // [RULE_18]
            wakeEn_d = regWdata[`UEH_BIT_WAKEEN];
            if (regWdata[`UEH_BIT_WAKESTS] && isD0 && !irqCause) begin
                wakeSts_d = 1'b0;
            end
        end else if (wrEn && regAddr == `UEH_OFS_CFGSTS) begin
            serrEn_d = regWdata[`UEH_BIT_SERREN];
            // write-one-to-clear, a same-cycle abort still lands
            rxMa_d = rxMa_d & ~(regWdata[`UEH_BIT_RXMA] & ~(abortEv & rdResp.masterAbort));
            rxTa_d = rxTa_d & ~(regWdata[`UEH_BIT_RXTA] & ~(abortEv & rdResp.targetAbort));
            sigSe_d = sigSe_d & ~(regWdata[`UEH_BIT_SIGSE] & ~(abortEv & serrEn_q));
        end else if (wrEn && regAddr == `UEH_OFS_FWPARAM) begin
            fwParam_d = regWdata;
        end
        if (coreClr) begin
            serrEn_d = 1'b0; // [RULE_23]
            rxMa_d = 1'b0;
            rxTa_d = 1'b0;
            sigSe_d = 1'b0;
        end
        if (sleepS345) begin
            pwr_d = `UEH_PWR_D0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pwr_q <= `UEH_PWR_D0;
            intRst_q <= 1'b0;
            serrEn_q <= 1'b0;
            rxMa_q <= 1'b0;
            rxTa_q <= 1'b0;
            sigSe_q <= 1'b0;
            fwParam_q <= `UEH_FW_RST;
            wakeEn_q <= 1'b0;
            wakeSts_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            intRst_q <= intRst_d;
            serrEn_q <= serrEn_d;
            rxMa_q <= rxMa_d;
            rxTa_q <= rxTa_d;
            sigSe_q <= sigSe_d;
            fwParam_q <= fwParam_d;
            wakeEn_q <= wakeEn_d;
            wakeSts_q <= wakeSts_d;
        end
    end
    // operational registers and the DMA halt machine
    always_comb begin
        stsSet = '0;
        stsSet[`UEH_BIT_USBINT] = xact.done & xact.ioc; // [RULE_04]
        stsSet[`UEH_BIT_ERRINT] = xact.done & xact.err; // [RULE_01]
        stsSet[`UEH_BIT_ROLL] = rollPulse; // [RULE_05]
        stsSet[`UEH_BIT_HSE] = abortEv; // [RULE_09] [RULE_01]
        stsClr = '0;
        run_d = run_q;
        pause_d = pause_q;
        hcRst_d = 1'b0;
        inten_d = inten_q;
        test_d = test_q;
        state_d = state_q;
        abortCnt_d = '0;
        if (wrEn && regAddr == `UEH_OFS_CMD) begin
            run_d = regWdata[`UEH_BIT_RUN];
            pause_d = regWdata[`UEH_BIT_PAUSE]; // [RULE_14]
            hcRst_d = regWdata[`UEH_BIT_HCRST];
        end else if (wrEn && regAddr == `UEH_OFS_STS) begin
            stsClr = regWdata[`UEH_STS_W-1:0];
        end else if (wrEn && regAddr == `UEH_OFS_INTEN) begin
            inten_d = regWdata[`UEH_STS_W-1:0];
        end else if (wrEn && regAddr == `UEH_OFS_TEST) begin
            // test packet gap timing is not held to spec, only the pattern is
            if (regWdata[3:0] <= `UEH_TEST_MAX) begin
                test_d = ueh_test_e'(regWdata[3:0]); // [RULE_22]
            end
        end
        // set wins over a same-cycle software clear
        sts_d = (sts_q & ~stsClr) | stsSet;
        case (state_q)
            ST_HALTED: begin
                if (run_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (abortEv) begin
                    state_d = ST_ABORT; // [RULE_03]
                end else if (!run_q) begin
                    state_d = ST_HALTED;
                end
            end
            ST_ABORT: begin
                abortCnt_d = abortCnt_q + ACW'(isD0 && abortCnt_q != '1);
                // one more transaction may finish; a microframe edge ends the wait
                if (xact.done || sofPulse) begin
                    state_d = ST_HALTED; // [RULE_10]
                    run_d = 1'b0; // [RULE_24]
                end
            end
            default: begin
                state_d = ST_HALTED;
            end
        endcase
        if (mmioClr) begin
            run_d = 1'b0;
            pause_d = 1'b0;
            sts_d = `UEH_STS_RST;
            inten_d = '0;
            test_d = TM_OFF;
            state_d = ST_HALTED;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_HALTED;
            abortCnt_q <= '0;
            run_q <= 1'b0;
            pause_q <= 1'b0;
            hcRst_q <= 1'b0;
            sts_q <= `UEH_STS_RST;
            inten_q <= '0;
            test_q <= TM_OFF;
        end else begin
            state_q <= state_d;
            abortCnt_q <= abortCnt_d;
            run_q <= run_d;
            pause_q <= pause_d;
            hcRst_q <= hcRst_d;
            sts_q <= sts_d;
            inten_q <= inten_d;
            test_q <= test_d;
        end
    end
    // read data, aborts, interrupt, grant and writeback
    always_comb begin
        rdata_d = '0;
        if (rdEn) begin
            if (regAddr == `UEH_OFS_CMD) begin
                rdata_d[`UEH_BIT_RUN] = run_q;
                rdata_d[`UEH_BIT_PAUSE] = pause_q;
            end else if (regAddr == `UEH_OFS_STS) begin
                rdata_d[`UEH_STS_W-1:0] = sts_q;
                rdata_d[`UEH_BIT_BUFERR] = 1'b0; // [RULE_02]
                rdata_d[`UEH_BIT_HALTED] = (state_q == ST_HALTED); // [RULE_24]
            end else if (regAddr == `UEH_OFS_INTEN) begin
                rdata_d[`UEH_STS_W-1:0] = inten_q;
            end else if (regAddr == `UEH_OFS_FRIDX) begin
                rdata_d[`UEH_FRIDX_W-1:0] = frIdx;
            end else if (regAddr == `UEH_OFS_TEST) begin
                rdata_d[3:0] = test_q;
            end else if (regAddr == `UEH_OFS_PWR) begin
                rdata_d[1:0] = pwr_q;
                rdata_d[`UEH_BIT_WAKEEN] = wakeEn_q;
                rdata_d[`UEH_BIT_WAKESTS] = wakeSts_q;
            end else if (regAddr == `UEH_OFS_CFGSTS) begin
                rdata_d[`UEH_BIT_SERREN] = serrEn_q;
                rdata_d[`UEH_BIT_RXTA] = rxTa_q;
                rdata_d[`UEH_BIT_RXMA] = rxMa_q;
                rdata_d[`UEH_BIT_SIGSE] = sigSe_q;
            end else if (regAddr == `UEH_OFS_PORTMAP) begin
                rdata_d[`UEH_MAX_PORTS*`UEH_CC_W-1:0] = map_q;
            end else if (regAddr == `UEH_OFS_FWPARAM) begin
                rdata_d = fwParam_q;
            end
        end
        regAbort_d = (regWr | regRd) & ~accOk; // [RULE_16]
        // paused or halted engines never touch memory
        grant_d = dmaReq & isD0 & run_q & ~pause_q & (state_q == ST_RUN) &
            ~sleepS345; // [RULE_14] [RULE_24]
        pll_d = ~sleepS345; // [RULE_20]
        // one line for every source, silenced in D3 where wake takes over
        irq_d = isD0 & irqCause; // [RULE_06] [RULE_11] [RULE_17]
        wake_d = wakeSts_q & wakeEn_q; // [RULE_17]
        wb_d.valid = xact.done;
        wb_d.error_retry_count = xact.error_retry_count;
        if (xact.intInSplit && !xact.splitOk) begin
            wb_d.error_retry_count = xact.error_retry_count; // [RULE_07]
        end else if (xact.err && xact.error_retry_count != 2'h0) begin
            wb_d.error_retry_count = xact.error_retry_count - 2'h1;
        end
        // a fetch that fails late start leaves the bit for a later pass
        wb_d.missed = xact.missed | (xact.cSplit & xact.lateMiss & ~xact.lateFail); // [RULE_08]
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= '0;
            regAbort_q <= 1'b0;
            grant_q <= 1'b0;
            pll_q <= 1'b0;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
            map_q <= '0;
            wb_q <= '0;
        end else begin
            rdata_q <= rdata_d;
            regAbort_q <= regAbort_d;
            grant_q <= grant_d;
            pll_q <= pll_d;
            irq_q <= irq_d;
            wake_q <= wake_d;
            map_q <= mapD;
            wb_q <= wb_d;
        end
    end
    assign regRdata = rdata_q;
    assign regAbort = regAbort_q;
    assign memGrant = grant_q;
    assign pllEnable = pll_q;
    assign sharedIrqLineH = irq_q;
    assign wakeEventSignal = wake_q;
    assign intResetPulse = intRst_q;
    assign portTestMode = test_q;
    assign companionMap = map_q;
    assign wb = wb_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_d3_settled;
        !isD0 ##1 !isD0;
    endsequence
    sequence s_wake_write;
        regWr && regAddr == `UEH_OFS_PWR && pwr_q == `UEH_PWR_D3 &&
            regWdata[1:0] == `UEH_PWR_D0;
    endsequence

    a_buf_err_zero: assert property ($past(stsRead) |-> !regRdata[`UEH_BIT_BUFERR]) // [RULE_02]
        else $error("buffer error reported");
    a_abort_sets_hse: assert property (abortEv && !mmioClr |=> sts_q[`UEH_BIT_HSE]) // [RULE_09]
        else $error("abort did not set host system error");
    a_abort_halts: assert property (state_q == ST_ABORT // [RULE_10]
        |-> abortCnt_q <= ACW'(UFRAME_CYC))
        else $error("engines did not halt after abort");
    a_irq_enabled: assert property (sharedIrqLineH |-> $past(irqCause) && $past(isD0)) // [RULE_11]
        else $error("interrupt without enabled cause");
    a_ma_bit: assert property (abortEv && rdResp.masterAbort && !coreClr |=> rxMa_q) // [RULE_12]
        else $error("master abort bit not set");
    a_system_error_report_gate: assert property (abortEv && !sigSe_q && !coreClr
        |=> sigSe_q == $past(serrEn_q)) // [RULE_13]
        else $error("signaled system error not gated by enable");
    a_pause_no_mem: assert property (pause_q |=> !memGrant) // [RULE_14]
        else $error("memory grant while paused");
    a_pwr_legal: assert property (pwr_q == `UEH_PWR_D0 || pwr_q == `UEH_PWR_D3) // [RULE_15]
        else $error("illegal power state");
    a_d3_mmio_abort: assert property ((regRd || regWr) && !isD0 && !isCfg
        |=> regAbort && regRdata == '0) // [RULE_16]
        else $error("d3 access not aborted");
    a_d3_no_irq: assert property (s_d3_settled |-> !sharedIrqLineH) // [RULE_17]
        else $error("interrupt asserted in d3");
    a_d3d0_reset: assert property (s_wake_write |=> intResetPulse ##1
        (!run_q && inten_q == '0 && !serrEn_q)) // [RULE_18]
        else $error("d3 to d0 write missed internal reset");
    a_sleep_pll: assert property (sleepS345 |=> !pllEnable && !memGrant) // [RULE_20]
        else $error("pll alive in sleep");
    a_halted_quiet: assert property (state_q == ST_HALTED |=> !memGrant) // [RULE_24]
        else $error("memory grant while halted");
    a_error_retry_count_hold: assert property (xact.done && xact.intInSplit && !xact.splitOk
        |=> wb.valid && wb.error_retry_count == $past(xact.error_retry_count)) // [RULE_07]
        else $error("retry count changed on unmet split");
    a_missed_late: assert property (xact.done && xact.cSplit && xact.lateFail
        |=> wb.missed == $past(xact.missed)) // [RULE_08]
        else $error("missed bit set on late start fail");
endmodule

// file: src/ueh_cfg.svh
// ueh_cfg.svh: register offsets, field positions, reset values and timing figures
// assumes: included by bare name by the package and by every design module
// Contract
// [RULE_01] every detected error condition is reported through an interrupt status bit
// [RULE_02] data buffer overrun/underrun cannot occur, so that status never rises
// [RULE_03] master or target abort on own memory read is fatal; controller halts
// [RULE_04] threshold interrupt may rise once status is posted internally, before memory
// [RULE_05] 1024-entry frame list; rollover interrupt every 1024 milliseconds
// [RULE_06] all interrupts leave on the single shared interrupt line
// [RULE_07] interrupt IN split with criteria unmet leaves error_retry_count unchanged
// [RULE_08] late-start fail never sets missed-microframe; later passing access sets it
// [RULE_09] aborted own read sets host system error status
// [RULE_10] after abort, DMA halts after at most one more USB transaction
// [RULE_11] abort raises interrupt only when host system error enable is set
// [RULE_12] abort sets received master abort or received target abort bit
// [RULE_13] abort sets signaled system error only with system_error_report enable
// [RULE_14] pause stops memory accesses while start-of-frame keeps running
// [RULE_15] power state accepts only D0 and D3; other writes leave it unchanged
// [RULE_16] register accesses in D3 end in master abort; configuration space (0x40 and up) still answers in D3
// [RULE_17] no interrupt in D3; wake events use wake_event_signal
// [RULE_18] writing D0 while in D3 generates an internal reset
// [RULE_19] software suspends or disables all root ports before entering D3
// [RULE_20] on S3/S4/S5 entry PLL is disabled and core logic reset
// [RULE_21] ports pair with companions: 0-1,2-3,4-5 first; 6-7,8-9 second
// [RULE_22] standard USB 2.0 test modes enterable, including Test J and Test Packet
// [RULE_23] internal reset spares firmware-programmed and suspend-well registers
// [RULE_24] after fatal error report halted and issue no memory traffic until restart
`ifndef UEH_CFG_SVH
`define UEH_CFG_SVH

`define UEH_ADDR_W 8
`define UEH_OFS_CMD 8'h00
`define UEH_OFS_STS 8'h04
`define UEH_OFS_INTEN 8'h08
`define UEH_OFS_FRIDX 8'h0C
`define UEH_OFS_TEST 8'h10
`define UEH_CFG_BASE 8'h40
`define UEH_OFS_PWR 8'h40
`define UEH_OFS_CFGSTS 8'h44
`define UEH_OFS_PORTMAP 8'h48
`define UEH_OFS_FWPARAM 8'h4C

`define UEH_BIT_RUN 0
`define UEH_BIT_PAUSE 1
`define UEH_BIT_HCRST 2
`define UEH_STS_W 5
`define UEH_BIT_USBINT 0
`define UEH_BIT_ERRINT 1
`define UEH_BIT_ROLL 3
`define UEH_BIT_HSE 4
`define UEH_BIT_BUFERR 5
`define UEH_BIT_HALTED 12
`define UEH_BIT_SERREN 0
`define UEH_BIT_RXTA 8
`define UEH_BIT_RXMA 9
`define UEH_BIT_SIGSE 10
`define UEH_BIT_WAKEEN 8
`define UEH_BIT_WAKESTS 15

`define UEH_PWR_D0 2'h0
`define UEH_PWR_D3 2'h3
`define UEH_TEST_MAX 4'h5
`define UEH_STS_RST 5'h00
`define UEH_FW_RST 32'h0000_0000

`define UEH_CLK_NS 100
`define UEH_UFRAME_NS 125000
`define UEH_FRIDX_W 13

`define UEH_MAX_PORTS 6
`define UEH_PORTS_HC0 6
`define UEH_PORTS_HC1 4
`define UEH_PORTS_PER_CC 2
`define UEH_CC_W 3
`define UEH_NO_COMPANION 3'h7

`endif

// file: src/ueh_pkg.sv
// ueh_pkg: types shared by the controller modules
// assumes: ueh_cfg.svh sits on the include path
`include "ueh_cfg.svh"
package ueh_pkg;
    typedef enum logic [2:0] {
        ST_HALTED = 3'h1,
        ST_RUN = 3'h2,
        ST_ABORT = 3'h4
    } ueh_dma_e;

    typedef enum logic [3:0] {
        TM_OFF = 4'h0,
        TM_J = 4'h1,
        TM_K = 4'h2,
        TM_SE0NAK = 4'h3,
        TM_PACKET = 4'h4,
        TM_FORCE = 4'h5
    } ueh_test_e;

    typedef struct packed {
        logic valid;
        logic masterAbort;
        logic targetAbort;
    } ueh_rdresp_s;

    typedef struct packed {
        logic done;
        logic ioc;
        logic err;
        logic intInSplit;
        logic splitOk;
        logic cSplit;
        logic lateFail;
        logic lateMiss;
        logic [1:0] error_retry_count;
        logic missed;
    } ueh_xact_s;

    typedef struct packed {
        logic valid;
        logic [1:0] error_retry_count;
        logic missed;
    } ueh_wb_s;
endpackage

// file: src/ueh_frame_timer.sv
// ueh_frame_timer: microframe divider and frame index
// assumes: rst_n already merged with every core-well reset source
`timescale 1ns/1ps
`include "ueh_cfg.svh"
module ueh_frame_timer import ueh_pkg::*; #(
    parameter int UFRAME_CYC = `UEH_UFRAME_NS / `UEH_CLK_NS
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous core reset, active low
    input wire logic run, // count microframes
    output logic sofPulse, // one cycle at each microframe start
    output logic rollPulse, // one cycle at frame list wrap
    output logic [`UEH_FRIDX_W-1:0] frIdx // microframe index
);
    localparam int CW = $clog2(UFRAME_CYC);
    localparam logic [CW-1:0] LAST = CW'(UFRAME_CYC - 1);

    logic [CW-1:0] cnt_q, cnt_d;
    logic [`UEH_FRIDX_W-1:0] idx_q, idx_d;
    logic sof_q, sof_d, roll_q, roll_d;

    always_comb begin
        cnt_d = cnt_q;
        idx_d = idx_q;
        sof_d = 1'b0;
        roll_d = 1'b0;
        if (run) begin
            if (cnt_q == LAST) begin
                cnt_d = '0;
                sof_d = 1'b1;
                idx_d = idx_q + 1'b1;
                // 8 microframes x 1024 frames wrap the index once per 1024 ms
                roll_d = &idx_q; // [RULE_05]
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= '0;
            idx_q <= '0;
            sof_q <= 1'b0;
            roll_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            sof_q <= sof_d;
            roll_q <= roll_d;
        end
    end

    assign sofPulse = sof_q;
    assign rollPulse = roll_q;
    assign frIdx = idx_q;

    a_roll_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rollPulse |-> sofPulse && frIdx == '0) // [RULE_05]
        else $error("rollover without index wrap");
endmodule

// file: dv/ueh_far_model.sv
// ueh_far_model: USB side and memory fabric answering the controller
// assumes: tasks are called from the bench between clk_sys edges
`timescale 1ns/1ps
module ueh_far_model import ueh_pkg::*; (
    input wire logic clk_sys, // system clock
    output ueh_rdresp_s rdResp, // read completion
    output ueh_xact_s xact // finished transaction
);
    initial begin
        rdResp = '0;
        xact = '0;
    end
    // ma high: master abort, else target abort
    task automatic abortRd(input logic ma);
        @(posedge clk_sys);
        rdResp <= '{1'b1, ma, !ma};
        @(posedge clk_sys);
        rdResp <= '0;
    endtask
    // f: err, intInSplit, splitOk, cSplit, lateFail, lateMiss
    task automatic done(input logic [5:0] f, input logic [1:0] c);
        @(posedge clk_sys);
        xact <= '{1'b1, 1'b0, f[5], f[4], f[3], f[2], f[1], f[0], c, 1'b0};
        @(posedge clk_sys);
        xact <= '0;
    endtask
endmodule

// file: dv/ueh_ctrl_tb_top.sv
// ueh_ctrl_tb_top: self-checking bench of the error and power block
// assumes: ueh_pkg compiled first; far side is ueh_far_model
`timescale 1ns/1ps
module ueh_ctrl_tb_top import ueh_pkg::*;;
    logic clk_sys = 0, rst_n = 0, regWr = 0, regRd = 0, dmaReq = 0, sleepS345 = 0, pend = 0, seen;
    logic [7:0] regAddr = '0;
    logic [31:0] regWdata = '0, regRdata, r;
    logic [32:0] q[$], e;
    logic regAbort, memGrant, pllEnable, sofPulse, sharedIrqLineH, wakeEventSignal;
    logic intResetPulse;
    logic [3:0] portTestMode;
    logic [17:0] companionMap;
    ueh_rdresp_s rdResp;
    ueh_xact_s xact;
    ueh_wb_s wb;
    int fail_count = 0, n_checks = 0;
    always #50 clk_sys = ~clk_sys;
    ueh_far_model ueh_far_model_inst (.clk_sys(clk_sys), .rdResp(rdResp), .xact(xact));
    ueh_ctrl #(.UFRAME_CYC(8)) ueh_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .regAbort(regAbort), .dmaReq(dmaReq), .memGrant(memGrant),
        .rdResp(rdResp), .xact(xact), .wb(wb), .sleepS345(sleepS345), .pllEnable(pllEnable),
        .sofPulse(sofPulse), .sharedIrqLineH(sharedIrqLineH),
        .wakeEventSignal(wakeEventSignal), .intResetPulse(intResetPulse),
        .portTestMode(portTestMode), .companionMap(companionMap));
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    // x[32] is the expected abort flag
    task automatic rd(logic [7:0] a, logic [32:0] x);
        @(posedge clk_sys);
        q.push_back(x);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
    endtask
    always @(posedge clk_sys) begin
        if (pend) begin
            e = q.pop_front();
            chk("regRdata", e[31:0], regRdata);
            chk("regAbort", {31'h0, e[32]}, {31'h0, regAbort});
        end
        pend <= regRd;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #2_000_000;
        fail_count++;
        stop_test();
    end
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    initial begin
        r = xs(32'haacd);
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1 chk("companionMap", 32'h0001_2240, {14'h0, companionMap});
        chk("pll", 32'h1, {31'h0, pllEnable});
        wr(8'h4C, r);
        rd(8'h4C, {1'b0, r});
        rd(8'hFC, 33'h0);
        wr(8'h10, 32'h0000_0004);
        wr(8'h10, 32'h0000_0006);
        #1 chk("testMode", 32'h4, {28'h0, portTestMode});
        $display("test map and regs done");
        ueh_far_model_inst.done(6'b110000, 2'h2);
        #1 chk("wb", 32'h6, {29'h0, wb.valid, wb.error_retry_count});
        ueh_far_model_inst.done(6'b100000, 2'h2);
        #1 chk("wb", 32'h5, {29'h0, wb.valid, wb.error_retry_count});
        ueh_far_model_inst.done(6'b000111, 2'h0);
        #1 chk("wb.missed", 32'h2, {30'h0, wb.valid, wb.missed});
        ueh_far_model_inst.done(6'b000101, 2'h0);
        #1 chk("wb.missed", 32'h3, {30'h0, wb.valid, wb.missed});
        $display("test transactions done");
        wr(8'h04, 32'h0000_003F);
        wr(8'h08, 32'h0000_0010);
        wr(8'h44, 32'h0000_0001);
        dmaReq <= 1'b1;
        wr(8'h00, 32'h0000_0001);
        ueh_far_model_inst.abortRd(1'b1);
        // a microframe edge ends the wait within 9 cycles here
        repeat (30) @(posedge clk_sys);
        #1 chk("irq", 32'h1, {31'h0, sharedIrqLineH});
        chk("memGrant", 32'h0, {31'h0, memGrant});
        rd(8'h04, 33'h0_0000_1010);
        rd(8'h44, 33'h0_0000_0601);
        wr(8'h44, 32'h0000_0700);
        ueh_far_model_inst.abortRd(1'b0);
        rd(8'h44, 33'h0_0000_0100);
        wr(8'h04, 32'h0000_003F);
        wr(8'h00, 32'h0000_0003);
        seen = 0;
        repeat (20) @(posedge clk_sys) seen |= sofPulse;
        #1 chk("sof", 32'h1, {31'h0, seen});
        chk("memGrant", 32'h0, {31'h0, memGrant});
        wr(8'h00, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        #1 chk("memGrant", 32'h1, {31'h0, memGrant});
        $display("test abort and pause done");
        wr(8'h00, 32'h0000_0000);
        wr(8'h40, 32'h0000_0001);
        rd(8'h40, 33'h0);
        wr(8'h40, 32'h0000_0103);
        rd(8'h40, 33'h0_0000_0103);
        rd(8'h04, 33'h1_0000_0000);
        ueh_far_model_inst.abortRd(1'b1);
        repeat (3) @(posedge clk_sys);
        #1 chk("irq", 32'h0, {31'h0, sharedIrqLineH});
        chk("wake", 32'h1, {31'h0, wakeEventSignal});
        wr(8'h40, 32'h0000_0000);
        seen = 0;
        repeat (3) @(posedge clk_sys) seen |= intResetPulse;
        chk("intReset", 32'h1, {31'h0, seen});
        rd(8'h4C, {1'b0, r});
        rd(8'h44, 33'h0);
        rd(8'h40, 33'h0_0000_8000);
        sleepS345 <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sleepS345 <= 1'b0;
        #1 chk("pll", 32'h0, {31'h0, pllEnable});
        repeat (2) @(posedge clk_sys);
        $display("test power done");
        stop_test();
    end
endmodule
